/* File: sct_pkg.sv */
package sct_pkg;
   // core clock period, the unit of every slave timing figure
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_SEZ_NS = 4 * CLK_PERIOD_NS;
   localparam int T_SDZ_NS = 4 * CLK_PERIOD_NS;
   localparam int T_SOH_NS = 4 * CLK_PERIOD_NS;
   localparam int SEZ_CYC = T_SEZ_NS / CLK_PERIOD_NS;
   localparam int SDZ_CYC = T_SDZ_NS / CLK_PERIOD_NS;
   localparam int SOH_CYC = T_SOH_NS / CLK_PERIOD_NS;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL = 10'h0a1;
   localparam logic [9:0] IDX_DIV = 10'h0a2;
   localparam logic [9:0] IDX_DATA = 10'h0a3;
   // serial_port_control field positions
   localparam int CTL_EN = 0;
   localparam int CTL_TXE = 1;
   localparam int CTL_MSTR = 2;
   localparam int CTL_POL = 3;
   localparam int CTL_PHA = 4;
   localparam int CTL_BUSY = 5;
   localparam int CTL_RXF = 6;
   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h02;
   localparam logic [7:0] DIV_RST = 8'h00;
   // index of the last serial clock half period and of the last bit in one byte
   localparam logic [3:0] LAST_HALF = 4'hf;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic {SCT_IDLE, SCT_RUN} sct_mstate_t;
endpackage

/* File: sct_link_if.sv */
`timescale 1ns/1ns
interface sct_link_if;
   logic [7:0] tx_byte; // byte to send, held by the core domain
   logic [7:0] rx_byte; // last byte received on the link
   logic rx_tgl; // flips once per received byte
   logic miso; // serial data toward the pin
   modport core(output tx_byte, input rx_byte, input rx_tgl, input miso);
   modport link(input tx_byte, output rx_byte, output rx_tgl, output miso);
endinterface

/* File: sct_link.sv */
`timescale 1ns/1ns
module sct_link (
   input wire logic i_link_clk, // serial clock from the external master
   input wire logic i_rst, // asynchronous reset, active high
   input wire logic i_mosi, // serial data from the master
   sct_link_if.link lnk // crossing toward the core domain
);
   import sct_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [6:0] rx;
      logic [7:0] rx_byte;
      logic tgl;
   } sct_link_st_t;

   sct_link_st_t r;
   sct_link_st_t n;
   logic [7:0] rxw;

   // bit 7 of a fresh byte comes straight from the hold register
   assign lnk.miso = (r.cnt == 3'h0) ? lnk.tx_byte[7] : r.sh[7];
   assign lnk.rx_byte = r.rx_byte;
   assign lnk.rx_tgl = r.tgl;
   assign rxw = {r.rx, i_mosi};

   // every rising edge samples one bit in and moves the next bit out
   always_comb begin
      n = r;
      n.rx = rxw[6:0];
      n.cnt = r.cnt + 3'h1;
      n.sh = (r.cnt == 3'h0) ? {lnk.tx_byte[6:0], 1'b0} : {r.sh[6:0], 1'b0};
      if (r.cnt == LAST_BIT) begin
         n.rx_byte = rxw;
         n.tgl = ~r.tgl; // toggle, so the core sees one event per byte
      end
   end

   // clock only runs inside frames; partial bytes leave cnt misaligned
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   property p_miso_next;
      @(posedge i_link_clk) disable iff (i_rst)
      (r.cnt == 3'h0) |=> (lnk.miso == $past(lnk.tx_byte[6]));
   endproperty
   a_miso_next: assert property (p_miso_next) else $error("miso not next bit");

   property p_byte_done;
      @(posedge i_link_clk) disable iff (i_rst)
      (r.cnt == LAST_BIT) |=> (r.tgl != $past(r.tgl)) && (r.rx_byte == $past(rxw));
   endproperty
   a_byte_done: assert property (p_byte_done) else $error("byte not delivered");
endmodule

/* File: sct_top.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
// How it works
// - moving the waiting byte into the shifter sets the buffer empty flag.
// - as master, polarity select high inverts the serial clock level and its edges.
// - as slave, MISO is driven within four core periods of select low.
// - as slave, MISO is released within four core periods of select high.
// - as slave, MISO follows each shifting edge within four core periods.
module sct_top #(
   parameter int ADDR_W = 12 // apb address width
) (
   input wire logic I_REF_CLK, // core clock
   input wire logic I_RST, // asynchronous reset, active high
   input wire logic I_PSEL, // apb select
   input wire logic I_PENABLE, // apb access phase
   input wire logic I_PWRITE, // apb direction, high for write
   input wire logic [ADDR_W-1:0] I_PADDR, // apb byte address
   input wire logic [31:0] I_PWDATA, // apb write data
   output logic [31:0] O_PRDATA, // apb read data
   output logic O_PREADY, // apb ready, always high
   output logic O_PSLVERR, // apb error on unmapped address
   input wire logic I_LINK_CLK, // serial clock pin as slave clock
   input wire logic I_MOSI, // mosi pin input
   input wire logic I_MISO, // miso pin input
   input wire logic I_NSS, // slave select pin input, low active
   output logic O_SCK, // serial clock out
   output logic O_SCK_OE, // serial clock drive enable
   output logic O_MOSI, // mosi out
   output logic O_MOSI_OE, // mosi drive enable
   output logic O_MISO, // miso out
   output logic O_MISO_OE, // miso drive enable
   output logic O_NSS, // slave select out, low active
   output logic O_NSS_OE // slave select drive enable
);
   import sct_pkg::*;

   initial begin
      if (ADDR_W < 12) begin
         $error("ADDR_W too small for the register map");
      end
   end

   typedef struct packed {
      logic en;
      logic txe;
      logic [1:0] smp_d;
      logic [1:0] fin_d;
      logic mstr;
      logic pol;
      logic pha;
      logic rxf;
      logic [7:0] div;
      logic [7:0] txbuf;
      logic [7:0] txhold;
      logic [7:0] rxdata;
      sct_mstate_t mst;
      logic [3:0] hcnt;
      logic [7:0] pcnt;
      logic [7:0] msh;
      logic [7:0] mrx;
      logic sck;
      logic mosi;
      logic nss_o;
      logic nss_s1;
      logic nss_s2;
      logic nss_d;
      logic miso_s1;
      logic miso_s2;
      logic tgl_s1;
      logic tgl_s2;
      logic tgl_d;
      logic ld_pend;
      logic miso_oe;
      logic [31:0] prdata;
      logic [12:0] xcyc;
   } sct_core_t;

   sct_core_t r;
   sct_core_t n;
   sct_link_if lnk();

   logic [9:0] idx;
   logic hit;
   logic apb_wr;
   logic apb_rd;
   logic wr_ctrl;
   logic wr_div;
   logic wr_data;
   logic busy;
   logic slave_on;
   logic move;
   logic sample_edge;
   logic [7:0] mrx_next;
   logic [12:0] xfer_len;

   sct_link u_link (
      .i_link_clk(I_LINK_CLK),
      .i_rst(I_RST),
      .i_mosi(I_MOSI),
      .lnk(lnk.link)
   );

   // apb decode; zero wait states, so an access completes in two cycles
   assign idx = I_PADDR[11:2];
   assign hit = (I_PADDR[1:0] == 2'b00) && ((I_PADDR >> 12) == '0)
                && ((idx == IDX_CTRL) || (idx == IDX_DIV) || (idx == IDX_DATA));
   assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE && hit;
   assign apb_rd = I_PSEL && I_PENABLE && !I_PWRITE && hit;
   assign wr_ctrl = apb_wr && (idx == IDX_CTRL);
   assign wr_div = apb_wr && (idx == IDX_DIV);
   assign wr_data = apb_wr && (idx == IDX_DATA);
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;
   assign O_PRDATA = r.prdata;

   // port outputs; a disabled port drives nothing
   assign busy = (r.mst == SCT_RUN);
   assign slave_on = r.en && !r.mstr;
   assign O_SCK = r.sck;
   assign O_SCK_OE = r.en && r.mstr;
   assign O_MOSI = r.mosi;
   assign O_MOSI_OE = r.en && r.mstr;
   assign O_NSS = r.nss_o;
   assign O_NSS_OE = r.en && r.mstr;
   assign O_MISO = lnk.miso;
   assign O_MISO_OE = r.miso_oe;
   assign lnk.tx_byte = r.txhold;

   // master shifting: even or odd edges sample depending on phase
   assign sample_edge = (r.hcnt[0] == r.pha);
   // capture waits two cycles so the miso synchroniser lag holds at any divider
   assign mrx_next = r.smp_d[1] ? {r.mrx[6:0], r.miso_s2} : r.mrx;
   // the byte leaves the buffer either into the master shifter or the slave hold
   assign move = ((r.mst == SCT_IDLE) && r.en && r.mstr && !r.txe && !wr_data)
                 || (r.ld_pend && slave_on && !r.txe && !wr_data);
   assign xfer_len = 13'(({5'h00, r.div} + 13'h0001) << 4);

   always_comb begin
      n = r;
      // synchronisers for the pins and the byte toggle
      n.nss_s1 = I_NSS;
      n.nss_s2 = r.nss_s1;
      n.nss_d = r.nss_s2;
      n.miso_s1 = I_MISO;
      n.miso_s2 = r.miso_s1;
      n.tgl_s1 = lnk.rx_tgl;
      n.tgl_s2 = r.tgl_s1;
      n.tgl_d = r.tgl_s2;
      // miso drive follows the synchronised select, three cycles at most
      n.miso_oe = slave_on && !r.nss_s2;
      // register writes
      if (wr_ctrl) begin
         n.en = I_PWDATA[CTL_EN];
         n.mstr = I_PWDATA[CTL_MSTR];
         n.pol = I_PWDATA[CTL_POL];
         n.pha = I_PWDATA[CTL_PHA];
      end
      if (wr_div) begin
         n.div = I_PWDATA[7:0];
      end
      if (wr_data) begin
         n.txbuf = I_PWDATA[7:0];
         n.txe = 1'b0;
      end
      // read data is captured in the setup cycle for the access cycle
      n.prdata = 32'h0000_0000;
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         if (idx == IDX_CTRL) begin
            n.prdata[CTL_EN] = r.en;
            n.prdata[CTL_TXE] = r.txe;
            n.prdata[CTL_MSTR] = r.mstr;
            n.prdata[CTL_POL] = r.pol;
            n.prdata[CTL_PHA] = r.pha;
            n.prdata[CTL_BUSY] = busy;
            n.prdata[CTL_RXF] = r.rxf;
         end else if (idx == IDX_DIV) begin
            n.prdata[7:0] = r.div;
         end else if (idx == IDX_DATA) begin
            n.prdata[7:0] = r.rxdata;
         end
      end
      // reading the data register clears the full flag; a new byte below wins
      if (apb_rd && (idx == IDX_DATA)) begin
         n.rxf = 1'b0;
      end
      // slave: select falling or a finished byte asks for the next byte
      if (slave_on && !r.nss_s2 && (r.nss_d || (r.tgl_s2 != r.tgl_d))) begin
         n.ld_pend = 1'b1;
      end else if (r.ld_pend && !wr_data) begin
         n.ld_pend = 1'b0;
      end
      if (slave_on && (r.tgl_s2 != r.tgl_d)) begin
         n.rxdata = lnk.rx_byte; // stable for a whole byte after the toggle
         n.rxf = 1'b1;
      end
      // delayed master capture; a finished byte sets the full flag
      n.smp_d = {r.smp_d[0], 1'b0};
      n.fin_d = {r.fin_d[0], 1'b0};
      n.mrx = mrx_next;
      if (r.fin_d[1]) begin
         n.rxdata = mrx_next;
         n.rxf = 1'b1;
      end
      if (r.ld_pend && slave_on && !r.txe && !wr_data) begin
         n.txhold = r.txbuf;
         n.txe = 1'b1;
      end
      // master sequencer
      unique case (r.mst)
         SCT_IDLE: begin
            n.sck = r.pol;
            n.nss_o = 1'b1;
            if (r.en && r.mstr && !r.txe && !wr_data) begin
               n.msh = r.txbuf;
               n.mosi = r.txbuf[7];
               n.txe = 1'b1;
               n.hcnt = 4'h0;
               n.pcnt = 8'h00;
               n.xcyc = 13'h0000;
               n.nss_o = 1'b0;
               n.mst = SCT_RUN;
            end
         end
         SCT_RUN: begin
            n.xcyc = r.xcyc + 13'h0001;
            if (!r.en || !r.mstr) begin
               // abandoning a byte returns the lines to idle at once
               n.mst = SCT_IDLE;
               n.sck = r.pol;
               n.nss_o = 1'b1;
            end else if (r.pcnt == r.div) begin
               // each half period lasts div plus one core cycles
               n.pcnt = 8'h00;
               n.sck = ~r.sck;
               n.hcnt = r.hcnt + 4'h1;
               n.smp_d[0] = sample_edge;
               if (!sample_edge && !(r.pha && (r.hcnt == 4'h0))) begin
                  n.msh = {r.msh[6:0], 1'b0};
                  n.mosi = r.msh[6];
               end
               if (r.hcnt == LAST_HALF) begin
                  n.fin_d[0] = 1'b1;
                  n.nss_o = 1'b1;
                  n.mst = SCT_IDLE;
               end
            end else begin
               n.pcnt = r.pcnt + 8'h01;
            end
         end
      endcase
   end

   // single state register of the core domain
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         r <= '0;
         r.en <= CTRL_RST[CTL_EN];
         r.txe <= CTRL_RST[CTL_TXE];
         r.mstr <= CTRL_RST[CTL_MSTR];
         r.pol <= CTRL_RST[CTL_POL];
         r.pha <= CTRL_RST[CTL_PHA];
         r.div <= DIV_RST;
         r.nss_o <= 1'b1;
         r.nss_s1 <= 1'b1;
         r.nss_s2 <= 1'b1;
         r.nss_d <= 1'b1;
      end else begin
         r <= n;
      end
   end

   localparam int SEZ_MAX = SEZ_CYC;
   localparam int SDZ_MAX = SDZ_CYC;

   sequence s_start;
      (r.mst == SCT_IDLE) ##1 (r.mst == SCT_RUN);
   endsequence

   sequence s_idle2;
      (!busy && r.en && r.mstr && !wr_ctrl) [*2];
   endsequence

   property p_txe_set;
      @(posedge I_REF_CLK) disable iff (I_RST)
      move |=> r.txe;
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("empty flag not set on move");

   property p_start_empty;
      @(posedge I_REF_CLK) disable iff (I_RST)
      s_start |-> r.txe && !O_NSS;
   endproperty
   a_start_empty: assert property (p_start_empty) else $error("start without empty flag");

   property p_disabled_quiet;
      @(posedge I_REF_CLK) disable iff (I_RST)
      !r.en && !wr_ctrl |=> !O_MISO_OE && !O_SCK_OE && !O_MOSI_OE && !busy;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("drive while disabled");

   property p_sck_hold;
      @(posedge I_REF_CLK) disable iff (I_RST)
      busy && (r.pcnt != r.div) && !apb_wr |=> $stable(O_SCK);
   endproperty
   a_sck_hold: assert property (p_sck_hold) else $error("sck changed early");

   property p_sck_toggle;
      @(posedge I_REF_CLK) disable iff (I_RST)
      busy && (r.pcnt == r.div) && !apb_wr |=> (O_SCK != $past(O_SCK));
   endproperty
   a_sck_toggle: assert property (p_sck_toggle) else $error("sck missed an edge");

   property p_xfer_len;
      @(posedge I_REF_CLK) disable iff (I_RST)
      $fell(busy) && r.en && r.mstr |-> (r.xcyc == xfer_len);
   endproperty
   a_xfer_len: assert property (p_xfer_len) else $error("byte time wrong");

   property p_idle_pol;
      @(posedge I_REF_CLK) disable iff (I_RST)
      s_idle2 |-> (O_SCK == r.pol);
   endproperty
   a_idle_pol: assert property (p_idle_pol) else $error("idle sck level wrong");

   property p_miso_on;
      @(posedge I_REF_CLK) disable iff (I_RST)
      slave_on && !wr_ctrl && $fell(I_NSS) ##1 (slave_on && !I_NSS) [*3]
      |-> ##[0:SEZ_MAX] O_MISO_OE;
   endproperty
   a_miso_on: assert property (p_miso_on) else $error("miso not driven in time");

   property p_miso_off;
      @(posedge I_REF_CLK) disable iff (I_RST)
      $rose(I_NSS) ##1 I_NSS [*3] |-> ##[0:SDZ_MAX] !O_MISO_OE;
   endproperty
   a_miso_off: assert property (p_miso_off) else $error("miso not released in time");
endmodule

/* File: sct_peer.sv */
`timescale 1ns/1ns
// far-side device: master when the core is slave, slave otherwise
module sct_peer (
   input wire logic i_slv, // 1: peer is master
   input wire logic i_go, // rising edge starts a frame
   input wire logic i_pol, // sck idle level as slave
   input wire logic [7:0] i_tx, // byte to send
   input wire logic i_sck, // sck pin
   input wire logic i_nss, // nss pin
   input wire logic i_mosi, // mosi pin
   input wire logic i_miso, // miso pin
   output logic o_sck, // sck as master
   output logic o_nss, // nss as master
   output logic o_mosi, // mosi as master
   output logic o_miso, // miso as slave
   output logic o_busy, // frame running
   output logic [7:0] o_rx // last byte received
);
   logic tick = 1'b0;
   logic [7:0] sh = 8'h00;
   // 15 ns base clock, unrelated in phase to the core clock
   initial begin
      forever begin
         #7 tick = 1'b1;
         #8 tick = 1'b0;
      end
   end
   initial begin
      o_sck = 1'b0;
      o_nss = 1'b1;
      o_mosi = 1'b0;
      o_miso = 1'b0;
      o_busy = 1'b0;
      o_rx = 8'h00;
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge tick);
   endtask
   // master frame; sck stands still outside it, half periods 105 ns
   always @(posedge i_go) begin
      if (i_slv) begin
         o_busy = 1'b1;
         o_nss = 1'b0;
         o_mosi = i_tx[7];
         ticks(6); // first edge 90 ns after select
         o_rx[7] = i_miso;
         for (int i = 7; i >= 0; i--) begin
            o_sck = 1'b1;
            ticks(7); // mosi held past the sample edge
            if (i > 0) o_rx[i-1] = i_miso;
            o_sck = 1'b0;
            if (i > 0) o_mosi = i_tx[i-1]; // set long before next sample edge
            ticks(7);
         end
         o_nss = 1'b1; // 105 ns after the last edge
         o_mosi = ~o_mosi; // released line keeps no stale bit
         o_busy = 1'b0;
      end
   end
   // slave side: load on select, sample leading edge, shift trailing edge
   always @(negedge i_nss) begin
      if (!i_slv) begin
         sh = i_tx;
         o_miso = sh[7];
      end
   end
   always @(posedge i_nss) begin
      if (!i_slv) o_miso = ~o_miso;
   end
   always @(i_sck) begin
      if (!i_slv && !i_nss) begin
         if (i_sck !== i_pol) begin
            o_rx = {o_rx[6:0], i_mosi};
         end else begin
            sh = {sh[6:0], 1'b0};
            o_miso = sh[7];
         end
      end
   end
endmodule

/* File: sct_top_tb.sv */
`timescale 1ns/1ns
module sct_top_tb;
   import sct_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, nss, nss_oe;
   logic p_slv = 1'b1;
   logic p_go = 1'b0;
   logic p_pol = 1'b0;
   logic [7:0] p_tx = 8'h00;
   logic [7:0] p_rx;
   logic p_sck, p_nss, p_mosi, p_miso, p_busy;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   // pin levels: whoever enables its driver owns the line
   wire sck_w = sck_oe ? sck : p_sck;
   wire nss_w = nss_oe ? nss : p_nss;
   wire mosi_w = mosi_oe ? mosi : p_mosi;
   wire miso_w = miso_oe ? miso : p_miso;
   sct_top u_sct_top (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LINK_CLK(sck_w), .I_MOSI(mosi_w),
      .I_MISO(miso_w), .I_NSS(nss_w), .O_SCK(sck), .O_SCK_OE(sck_oe), .O_MOSI(mosi),
      .O_MOSI_OE(mosi_oe), .O_MISO(miso), .O_MISO_OE(miso_oe), .O_NSS(nss), .O_NSS_OE(nss_oe));
   sct_peer u_sct_peer (.i_slv(p_slv), .i_go(p_go), .i_pol(p_pol), .i_tx(p_tx),
      .i_sck(sck_w), .i_nss(nss_w), .i_mosi(mosi_w), .i_miso(miso_w), .o_sck(p_sck),
      .o_nss(p_nss), .o_mosi(p_mosi), .o_miso(p_miso), .o_busy(p_busy), .o_rx(p_rx));
   initial begin
      forever #10 clk = ~clk;
   end
   // hang guard, well above the longest byte at divider 255
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; an idle edge follows so strobes never re-assert in one step
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb(1'b1, idx, wd, d, e);
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
      chk(d, exp);
   endtask
   task automatic s_regs();
      logic [31:0] d;
      logic e;
      rdc(IDX_CTRL, {24'h0, CTRL_RST});
      rdc(IDX_DIV, {24'h0, DIV_RST});
      wr(IDX_DIV, 32'h5a);
      rdc(IDX_DIV, 32'h5a);
      // enable stays low here: a driven sck would clock the slave shifter
      wr(IDX_CTRL, 32'hfe);
      rdc(IDX_CTRL, 32'h1e);
      wr(IDX_CTRL, 32'h00);
      apb(1'b0, 10'h0a4, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
   endtask
   // core as slave; miso must follow select within four core periods
   task automatic s_slave(input logic en);
      int k;
      wr(IDX_CTRL, {31'h0, en});
      wr(IDX_DATA, 32'h96);
      p_slv <= 1'b1;
      p_tx <= 8'h5b;
      repeat (8) @(posedge clk);
      if (en) rdc(IDX_CTRL, 32'h01);
      p_go <= 1'b1;
      @(posedge clk);
      p_go <= 1'b0;
      while (nss_w !== 1'b0) @(posedge clk);
      k = 0;
      while (miso_oe !== 1'b1 && k < 8) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, k <= 4}, {31'h0, en});
      while (nss_w !== 1'b1) @(posedge clk);
      k = 0;
      while (miso_oe !== 1'b0 && k < 8) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, k <= 4}, 32'h1);
      while (p_busy === 1'b1) @(posedge clk);
      if (en) chk({24'h0, p_rx}, 32'h96);
      rdc(IDX_DATA, 32'h5b);
   endtask
   // core as master: byte held back while disabled, then timed on the pins
   task automatic s_master(input logic [7:0] div, input logic pol, input logic [7:0] sb);
      int k;
      int tg;
      int gap;
      int gmin;
      int gmax;
      logic last;
      logic [7:0] db;
      db = 8'hc3 ^ div;
      p_slv <= 1'b0;
      p_pol <= pol;
      p_tx <= sb;
      wr(IDX_DIV, {24'h0, div});
      wr(IDX_CTRL, {28'h0, pol, 3'h4});
      wr(IDX_DATA, {24'h0, db});
      repeat (20) @(posedge clk);
      chk({31'h0, nss_oe}, 32'h0);
      rdc(IDX_CTRL, {28'h0, pol, 3'h4});
      wr(IDX_CTRL, {28'h0, pol, 3'h5});
      k = 0;
      while (nss !== 1'b0 && k < 50) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, sck}, {31'h0, pol});
      last = sck;
      tg = 0;
      gap = 0;
      gmin = 9999;
      gmax = 0;
      while (nss === 1'b0) begin
         @(posedge clk);
         gap++;
         if (sck !== last) begin
            tg++;
            if (tg > 1 && gap < gmin) gmin = gap;
            if (tg > 1 && gap > gmax) gmax = gap;
            gap = 0;
            last = sck;
         end
      end
      chk(tg, 16);
      chk(gmin, div + 1);
      chk(gmax, div + 1);
      chk({31'h0, sck}, {31'h0, pol});
      chk({24'h0, p_rx}, {24'h0, db});
      // received byte lands two cycles after the frame, behind the miso synchroniser
      repeat (2) @(posedge clk);
      rdc(IDX_DATA, {24'h0, sb});
      rdc(IDX_CTRL, {28'h0, pol, 3'h7});
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_regs();
      s_slave(1'b1);
      s_slave(1'b0);
      s_master(8'h00, 1'b0, 8'ha5);
      s_master(8'h04, 1'b1, 8'h3c);
      s_master(8'hff, 1'b0, 8'h81);
      stop_test();
   end
endmodule
